// ---- src/kpint_pkg.sv ----
// package for the key-switch interrupt logic: register address, field
// layout, reset value and pacing constants
// assumes a serial-bus front end that decodes register addresses
package kpint_pkg;
  localparam logic [7:0] INT_REG_ADDR = 8'h03;
  localparam int PEND_BIT = 7;
  localparam int ALERT_BIT = 6;
  localparam int KEY_BIT = 5;
  localparam int PACE_MSB = 4;
  localparam int PACE_W = 5;
  localparam logic [7:0] INT_REG_RESET = 8'h00;
  localparam logic [4:0] PACE_OFF = 5'h00;
  localparam logic [4:0] PACE_ONE = 5'h01;
endpackage

// ---- src/pace_counter.sv ----
// modulo-n counter of completed debounce cycles
// assumes dbEnd is a one-cycle pulse on mclk
`timescale 1ns/1ps
module pace_counter #(
  parameter int W = 5
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic dbEnd,
  input wire logic [W-1:0] period,
  output logic wrap
);
  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;
  logic atTop;

  // a zero period counts as one so status keeps updating every cycle
  assign atTop = (cnt_q + {{(W-1){1'b0}}, 1'b1} >= period);
  assign wrap = dbEnd && atTop;
  assign cnt_d = !dbEnd ? cnt_q
               : atTop ? '0
               : cnt_q + {{(W-1){1'b0}}, 1'b1};

  // counter restarts whenever the period is reached or exceeded
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      cnt_q <= '0;
    end
    else
    begin
      cnt_q <= cnt_d;
    end
  end
endmodule

// ---- src/keypad_interrupt_logic.sv ----
// interrupt status and pacing logic of a key-switch monitoring controller
// assumes a serial-bus front end gives addressed read/write strobes on mclk
// and that key fifo and debounce signals come from logic on the same clock
`timescale 1ns/1ps

module keypad_interrupt_logic (
  input wire logic mclk,
  input wire logic rst,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] wrData,
  output logic [7:0] rdData,
  input wire logic dbEnd,
  input wire logic newKey,
  input wire logic fifoEmpty,
  input wire logic alertFall,
  input wire logic alertIntEn,
  input wire logic alertImmediate,
  input wire logic intPortLevel,
  output logic intPinN
);
  // ****************************************************************
  // decode and event logic
  // ****************************************************************
  // pacing field, the only part of the register that a write can change
  logic [kpint_pkg::PACE_W-1:0] pace_q;
  logic keyFlag_q;
  logic alertFlag_q;
  logic keyHeld_q;
  logic alertHeld_q;
  logic intPinN_q;
  logic [7:0] rdData_q;
  logic hit;
  logic wrHit;
  logic rdHit;
  logic wrap;
  logic alertEvt;
  logic keySet;
  logic alertSet;
  logic keyHeld_d;
  logic alertHeld_d;
  logic keyFlag_d;
  logic alertFlag_d;
  logic pend;
  logic [7:0] regView;
  logic [7:0] rdData_d;
  logic intPinN_d;
  logic gpoMode;
  logic [kpint_pkg::PACE_W-1:0] wrPace;

  assign hit = (regAddr == kpint_pkg::INT_REG_ADDR);
  assign wrHit = regWrite && hit;
  assign rdHit = regRead && hit;
  assign alertEvt = alertFall && alertIntEn;

  // new keys wait for the wrap; paced alerts wait too, immediate do not
  assign keyHeld_d = (keyHeld_q || newKey) && !wrap;
  assign alertHeld_d = (alertHeld_q || (alertEvt && !alertImmediate))
                       && !wrap;
  assign keySet = wrap && (keyHeld_q || newKey);
  assign alertSet = (alertEvt && alertImmediate)
                    || (wrap && (alertHeld_q || alertEvt));

  // set wins over clear: an event in the read cycle is never lost
  assign keyFlag_d = keySet || (keyFlag_q && !fifoEmpty);
  assign alertFlag_d = alertSet || (alertFlag_q && !rdHit);
  assign pend = keyFlag_q || alertFlag_q;
  assign regView = {pend, alertFlag_q, keyFlag_q, pace_q};

  // write data reaches only the pacing field; flag bits are dropped
  assign wrPace = wrData[kpint_pkg::PACE_MSB:0];

  // read data is zero unless this register is addressed, so a read
  // aimed at another register never leaks status onto the bus
  assign rdData_d = rdHit ? regView : 8'h00;
  // a zero pacing field hands the pin over to the ports register;
  // the flags still run, so the host can poll instead of waiting
  assign gpoMode = (pace_q == kpint_pkg::PACE_OFF);
  assign intPinN_d = gpoMode ? intPortLevel : !pend;

  // the counter reads the live pacing field: a write takes effect at the
  // next debounce end and is not a restart, so a lower value wraps early
  pace_counter #(
    .W(kpint_pkg::PACE_W)
  ) u_pace (
    .mclk(mclk),
    .rst(rst),
    .dbEnd(dbEnd),
    .period(pace_q),
    .wrap(wrap)
  );

  // ****************************************************************
  // registers
  // ****************************************************************
  // only the pacing field is writable; flags ignore write data
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      pace_q <= kpint_pkg::INT_REG_RESET[kpint_pkg::PACE_MSB:0];
      keyFlag_q <= 1'b0;
      alertFlag_q <= 1'b0;
      keyHeld_q <= 1'b0;
      alertHeld_q <= 1'b0;
    end
    else
    begin
      if (wrHit)
        pace_q <= wrPace;
      keyFlag_q <= keyFlag_d;
      alertFlag_q <= alertFlag_d;
      keyHeld_q <= keyHeld_d;
      alertHeld_q <= alertHeld_d;
    end
  end

  // read data and pin registered so outputs come from flip-flops
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      rdData_q <= kpint_pkg::INT_REG_RESET;
      intPinN_q <= 1'b1;
    end
    else
    begin
      rdData_q <= rdData_d;
      intPinN_q <= intPinN_d;
    end
  end

  assign rdData = rdData_q;
  assign intPinN = intPinN_q;

  // ****************************************************************
  // assertions
  // ****************************************************************
  // register view and read side effects
  pend_flags_a: assert property (
    @(posedge mclk) disable iff (rst)
    rdHit |=> rdData[kpint_pkg::PEND_BIT]
      == (rdData[kpint_pkg::ALERT_BIT] || rdData[kpint_pkg::KEY_BIT]))
    else $error("pending bit does not match cause bits");
  both_causes_a: assert property (
    @(posedge mclk) disable iff (rst)
    rdHit && keyFlag_q && alertFlag_q
    |=> rdData[kpint_pkg::PEND_BIT] && rdData[kpint_pkg::ALERT_BIT]
      && rdData[kpint_pkg::KEY_BIT])
    else $error("both causes not reported together");
  unmapped_read_a: assert property (
    @(posedge mclk) disable iff (rst)
    regRead && !hit |=> rdData == 8'h00)
    else $error("unaddressed read returned data");
  read_clears_alert_a: assert property (
    @(posedge mclk) disable iff (rst)
    rdHit && !alertSet |=> !alertFlag_q)
    else $error("alert flag survived a register read");
  read_keeps_key_a: assert property (
    @(posedge mclk) disable iff (rst)
    rdHit && keyFlag_q && !fifoEmpty |=> keyFlag_q)
    else $error("read cleared key flag");
  fifo_clears_key_a: assert property (
    @(posedge mclk) disable iff (rst)
    keyFlag_q && fifoEmpty && !keySet |=> !keyFlag_q)
    else $error("key flag not cleared by empty fifo");
  write_pace_a: assert property (
    @(posedge mclk) disable iff (rst)
    wrHit |=> pace_q == $past(wrPace))
    else $error("pacing field not written");

  // pin behaviour in both modes
  pin_port_a: assert property (
    @(posedge mclk) disable iff (rst)
    pace_q == kpint_pkg::PACE_OFF && $stable(pace_q)
    |=> intPinN == $past(intPortLevel))
    else $error("pin not following port level");
  pin_int_a: assert property (
    @(posedge mclk) disable iff (rst)
    pace_q != kpint_pkg::PACE_OFF && $stable(pace_q)
    |=> intPinN == !$past(pend))
    else $error("pin does not show pending interrupt");

  // pacing of key and alert causes
  key_paced_a: assert property (
    @(posedge mclk) disable iff (rst)
    !keyFlag_q && !dbEnd |=> !keyFlag_q)
    else $error("key flag raised off a debounce end");
  key_needs_new_a: assert property (
    @(posedge mclk) disable iff (rst)
    !keyFlag_q && !keyHeld_q && !newKey |=> !keyFlag_q)
    else $error("key flag raised with no new key");
  key_wait_a: assert property (
    @(posedge mclk) disable iff (rst)
    keyHeld_q && !dbEnd |=> keyHeld_q)
    else $error("new key dropped before the pacing wrap");
  zero_pace_a: assert property (
    @(posedge mclk) disable iff (rst)
    pace_q == kpint_pkg::PACE_OFF && dbEnd && newKey |=> keyFlag_q)
    else $error("zero pacing did not update key flag");
  alert_gate_a: assert property (
    @(posedge mclk) disable iff (rst)
    !alertFlag_q && !alertHeld_q && !(alertFall && alertIntEn)
    |=> !alertFlag_q)
    else $error("alert flag without enabled falling edge");
  alert_now_a: assert property (
    @(posedge mclk) disable iff (rst)
    alertFall && alertIntEn && alertImmediate |=> alertFlag_q)
    else $error("immediate alert not flagged");
  alert_wait_a: assert property (
    @(posedge mclk) disable iff (rst)
    alertFall && alertIntEn && !alertImmediate && !wrap
    |=> alertHeld_q)
    else $error("paced alert not held for the wrap");

  // ****************************************************************
  // coverage of the main scenarios
  // ****************************************************************
  // each goal marks a scenario the bench is expected to reach
  key_raise_c: cover property (@(posedge mclk) disable iff (rst)
    newKey ##[1:40] keySet);
  both_c: cover property (@(posedge mclk) disable iff (rst)
    keyFlag_q && alertFlag_q);
  gpo_c: cover property (@(posedge mclk) disable iff (rst)
    pace_q == kpint_pkg::PACE_OFF && keySet);
  alert_paced_c: cover property (@(posedge mclk) disable iff (rst)
    alertHeld_q && wrap);
  gpo_follow_c: cover property (@(posedge mclk) disable iff (rst)
    pace_q == kpint_pkg::PACE_OFF && $fell(intPinN));
endmodule

// ---- dv/host_model.sv ----
// host model: the microprocessor side of the interrupt register bus
// assumes strobes are sampled by the block on the rising edge of mclk
`timescale 1ns/1ps
module host_model (
  input wire logic mclk,
  output logic regWrite,
  output logic regRead,
  output logic [7:0] regAddr,
  output logic [7:0] wrData,
  input wire logic [7:0] rdData
);
  // bus idle until the first access after reset
  initial
  begin
    regWrite = 1'b0;
    regRead = 1'b0;
    regAddr = 8'h00;
    wrData = 8'h00;
  end

  // one access: strobe held one cycle, read data taken one edge later
  task automatic acc(input logic w, input logic [7:0] a, d,
                     output logic [7:0] q);
    @(posedge mclk);
    regWrite <= w;
    regRead <= !w;
    regAddr <= a;
    wrData <= d;
    @(posedge mclk);
    regWrite <= 1'b0;
    regRead <= 1'b0;
    wrData <= ~d; // released data must not linger
    #1 q = rdData;
  endtask
endmodule

// ---- dv/keypad_interrupt_logic_test.sv ----
// self-checking bench for the key-switch interrupt logic
// assumes host_model drives the register strobes on mclk
`timescale 1ns/1ps
module keypad_interrupt_logic_test;
  logic mclk, rst, regWrite, regRead, dbEnd, newKey, fifoEmpty;
  logic alertFall, alertIntEn, alertImmediate, intPortLevel, intPinN;
  logic [7:0] regAddr, wrData, rdData, q;
  int failures, checked;

  keypad_interrupt_logic u_keypad_interrupt_logic (.mclk, .rst,
    .regWrite, .regRead, .regAddr, .wrData, .rdData, .dbEnd, .newKey,
    .fifoEmpty, .alertFall, .alertIntEn, .alertImmediate,
    .intPortLevel, .intPinN);
  host_model host (.mclk, .regWrite, .regRead, .regAddr, .wrData, .rdData);

  // ************
  // helpers
  // ************
  task automatic chk(input string n, input logic [7:0] e, g);
    checked++;
    if (g !== e)
    begin
      failures++;
      $display("[FAIL] %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic rd(input logic [7:0] e);
    host.acc(1'b0, 8'h03, 8'h00, q);
    chk("intReg", e, q);
  endtask
  task automatic wr(input logic [7:0] d);
    host.acc(1'b1, 8'h03, d, q);
  endtask
  // one-cycle event, then wait until the pin has followed
  task automatic ev(input logic d, k, f, a);
    @(posedge mclk);
    dbEnd <= d;
    newKey <= k;
    fifoEmpty <= f;
    alertFall <= a;
    @(posedge mclk);
    {dbEnd, newKey, fifoEmpty, alertFall} <= 4'h0;
    @(posedge mclk);
    #1;
  endtask
  task automatic report_and_stop;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // ************
  // scenarios
  // ************
  task automatic t_keys;
    rd(8'h00);
    chk("pin", {7'h0, intPortLevel}, {7'h0, intPinN});
    host.acc(1'b0, 8'h05, 8'h00, q);
    chk("unmapped", 8'h00, q);
    wr(8'hff);
    rd(8'h1f);
    wr(8'h01);
    ev(1'b0, 1'b1, 1'b0, 1'b0);
    rd(8'h01);
    ev(1'b1, 1'b0, 1'b0, 1'b0);
    chk("pin", 8'h00, {7'h0, intPinN});
    rd(8'ha1);
    rd(8'ha1);
    ev(1'b0, 1'b0, 1'b1, 1'b0);
    rd(8'h01);
    wr(8'h02);
    ev(1'b1, 1'b1, 1'b0, 1'b0);
    rd(8'h02);
    ev(1'b1, 1'b0, 1'b0, 1'b0);
    rd(8'ha2);
    ev(1'b0, 1'b0, 1'b1, 1'b0);
  endtask
  task automatic t_alert;
    wr(8'h01);
    ev(1'b0, 1'b0, 1'b0, 1'b1);
    rd(8'h01);
    @(posedge mclk);
    {alertIntEn, alertImmediate} <= 2'h3;
    ev(1'b0, 1'b0, 1'b0, 1'b1);
    rd(8'hc1);
    rd(8'h01);
    ev(1'b1, 1'b1, 1'b0, 1'b1);
    rd(8'he1);
    ev(1'b0, 1'b0, 1'b1, 1'b0);
    @(posedge mclk);
    alertImmediate <= 1'b0;
    ev(1'b0, 1'b0, 1'b0, 1'b1);
    rd(8'h01);
    ev(1'b1, 1'b0, 1'b0, 1'b0);
    rd(8'hc1);
  endtask
  task automatic t_gpo;
    wr(8'h00);
    @(posedge mclk);
    intPortLevel <= 1'b0;
    ev(1'b1, 1'b1, 1'b0, 1'b0);
    chk("gpoLow", 8'h00, {7'h0, intPinN});
    @(posedge mclk);
    intPortLevel <= 1'b1;
    ev(1'b0, 1'b0, 1'b0, 1'b0);
    chk("gpoHigh", 8'h01, {7'h0, intPinN});
    rd(8'ha0);
  endtask

  // clock, reset and a bound on the whole run
  initial
  begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  initial
  begin
    repeat (5000) @(posedge mclk);
    failures++;
    report_and_stop();
  end
  initial
  begin
    {rst, intPortLevel} = 2'h3;
    {dbEnd, newKey, fifoEmpty, alertFall, alertIntEn, alertImmediate} = 6'h0;
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    t_keys();
    t_alert();
    t_gpo();
    report_and_stop();
  end
endmodule
